// ### verilog/scs_sequencer.v
`timescale 1ns/1ps
`include "scs_map.vh"

// How it works
// - start rising edge ends acquisition, begins conversion
// - open short switches, then ground both arrays
// - sixteen weighted trials, msb first, one decision each
// - afterwards reacquire, publish code, flag conversion end
// - own clock times conversion; serial clock ignored
// - result is sixteen-bit straight binary
// - overrange input gives all ones
// - underrange input gives all zeros
// - result belongs to its own start edge
// - low-power state between conversions
// - back-to-back conversions every 21 clocks, just short of one megasample
// - started conversion ignores later start activity
// - cs mode busy only if start/serial low
module scs_sequencer #(
	parameter RES_BITS   = `SCS_RES_BITS,
	parameter BIT_CYCLES = `SCS_BIT_CYCLES
) (
	input  wire                SYS_CLK,
	input  wire                RST_N,
	input  wire                CONVERSION_START_INPUT,
	input  wire                SERIAL_IN_MODE_SELECT,
	input  wire                COMP_DECISION,
	input  wire                OVER_RANGE,
	input  wire                UNDER_RANGE,
	output reg                 POSITIVE_ARRAY_SHORT_SWITCH,
	output reg                 NEGATIVE_ARRAY_SHORT_SWITCH,
	output reg                 ARRAY_TO_INPUT,
	output reg                 ARRAY_TO_GROUND,
	output wire [RES_BITS-1:0] DAC_CODE,
	output reg  [RES_BITS-1:0] RESULT,
	output reg                 RESULT_VALID,
	output reg                 BUSY_INDICATOR,
	output reg                 CONVERTING,
	output reg                 POWER_DOWN,
	output reg                 CS_MODE,
	output reg                 START_IGNORED
);

	localparam ST_ACQ  = `SCS_ST_ACQ;
	localparam ST_OPEN = `SCS_ST_OPEN;
	localparam ST_DISC = `SCS_ST_DISC;
	localparam ST_CONV = `SCS_ST_CONV;
	localparam ST_DONE = `SCS_ST_DONE;
	localparam CNT_W   = 8;
	localparam [CNT_W-1:0] BIT_LAST = BIT_CYCLES - 1;

	// synchroniser stages; the first stage feeds only the second
	reg                  start_s1_reg;
	reg                  start_s2_reg;
	reg                  start_s3_reg;
	reg                  serial_s1_reg;
	reg                  serial_s2_reg;
	reg                  over_s1_reg;
	reg                  over_s2_reg;
	reg                  under_s1_reg;
	reg                  under_s2_reg;

	reg [`SCS_ST_W-1:0]  state_reg;
	reg [`SCS_ST_W-1:0]  state_next;
	reg [CNT_W-1:0]      bit_cnt_reg;
	reg [CNT_W-1:0]      bit_cnt_next;
	reg                  sar_start;
	reg                  sar_step;

	wire                 start_rise;
	wire [RES_BITS-1:0]  sar_code;
	wire                 sar_done;
	reg  [RES_BITS-1:0]  result_next;

	// two-flop synchronisers for every pin-side input
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			start_s1_reg  <= 1'b0;
			start_s2_reg  <= 1'b0;
			start_s3_reg  <= 1'b0;
			serial_s1_reg <= 1'b0;
			serial_s2_reg <= 1'b0;
			over_s1_reg   <= 1'b0;
			over_s2_reg   <= 1'b0;
			under_s1_reg  <= 1'b0;
			under_s2_reg  <= 1'b0;
		end else begin
			start_s1_reg  <= CONVERSION_START_INPUT;
			start_s2_reg  <= start_s1_reg;
			start_s3_reg  <= start_s2_reg;
			serial_s1_reg <= SERIAL_IN_MODE_SELECT;
			serial_s2_reg <= serial_s1_reg;
			over_s1_reg   <= OVER_RANGE;
			over_s2_reg   <= over_s1_reg;
			under_s1_reg  <= UNDER_RANGE;
			under_s2_reg  <= under_s1_reg;
		end
	end

	// edge taken from the settled stages only
	assign start_rise = start_s2_reg & ~start_s3_reg;

	// the approximation register and its trial pointer
	scs_sar_core #(
		.N        (RES_BITS)
	) u_sar (
		.clk      (SYS_CLK),
		.rst_n    (RST_N),
		.start    (sar_start),
		.step     (sar_step),
		.decision (COMP_DECISION),
		.code_reg (sar_code),
		.done_reg (sar_done)
	);

	// trial code drives the array switches straight from the register
	assign DAC_CODE = sar_code;

	// sequencing; only the internal clock advances it, no serial clock
	always @* begin
		state_next   = state_reg;
		bit_cnt_next = bit_cnt_reg;
		sar_start    = 1'b0;
		sar_step     = 1'b0;
		case (state_reg)
			ST_ACQ: begin
				if (start_rise) begin
					state_next = ST_OPEN;
				end
			end
			ST_OPEN: begin
				state_next = ST_DISC;
			end
			ST_DISC: begin
				state_next   = ST_CONV;
				sar_start    = 1'b1;
				bit_cnt_next = {CNT_W{1'b0}};
			end
			ST_CONV: begin
				// start edges are not looked at here
				if (sar_done) begin
					state_next = ST_DONE;
				end else if (bit_cnt_reg == BIT_LAST) begin
					sar_step     = 1'b1;
					bit_cnt_next = {CNT_W{1'b0}};
				end else begin
					bit_cnt_next = bit_cnt_reg + 8'h01;
				end
			end
			ST_DONE: begin
				state_next = ST_ACQ;
			end
			default: begin
				state_next = ST_ACQ;
			end
		endcase
	end

	// clamp at both ends rather than wrap; in range the code is straight binary
	always @* begin
		if (over_s2_reg) begin
			result_next = `SCS_CODE_FULL;
		end else if (under_s2_reg) begin
			result_next = `SCS_CODE_ZERO;
		end else begin
			result_next = sar_code;
		end
	end

	// state and bit timer
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg   <= ST_ACQ;
			bit_cnt_reg <= {CNT_W{1'b0}};
		end else begin
			state_reg   <= state_next;
			bit_cnt_reg <= bit_cnt_next;
		end
	end

	// analog switch controls; break before make so the sample is not disturbed
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			POSITIVE_ARRAY_SHORT_SWITCH <= 1'b1;
			NEGATIVE_ARRAY_SHORT_SWITCH <= 1'b1;
			ARRAY_TO_INPUT              <= 1'b1;
			ARRAY_TO_GROUND             <= 1'b0;
		end else begin
			if (state_reg == ST_ACQ && start_rise) begin
				POSITIVE_ARRAY_SHORT_SWITCH <= 1'b0;
				NEGATIVE_ARRAY_SHORT_SWITCH <= 1'b0;
			end else if (state_reg == ST_OPEN) begin
				ARRAY_TO_INPUT  <= 1'b0;
				ARRAY_TO_GROUND <= 1'b1;
			end else if (state_reg == ST_DONE) begin
				// back to tracking the inputs
				POSITIVE_ARRAY_SHORT_SWITCH <= 1'b1;
				NEGATIVE_ARRAY_SHORT_SWITCH <= 1'b1;
				ARRAY_TO_INPUT              <= 1'b1;
				ARRAY_TO_GROUND             <= 1'b0;
			end
		end
	end

	// result publish; held until the next completion overwrites it
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			RESULT       <= `SCS_CODE_ZERO;
			RESULT_VALID <= 1'b0;
		end else begin
			RESULT_VALID <= 1'b0;
			if (state_reg == ST_CONV && sar_done) begin
				RESULT       <= result_next;
				RESULT_VALID <= 1'b1;
			end
		end
	end

	// interface mode latched at each accepted start edge
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			CS_MODE <= 1'b0;
		end else if (state_reg == ST_ACQ && start_rise) begin
			CS_MODE <= serial_s2_reg;
		end
	end

	// busy flag: armed only in cs mode with a select line low at the end
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			BUSY_INDICATOR <= 1'b0;
		end else if (state_reg == ST_CONV && sar_done) begin
			BUSY_INDICATOR <= CS_MODE & (~start_s2_reg | ~serial_s2_reg);
		end else if (state_reg == ST_ACQ && start_rise) begin
			BUSY_INDICATOR <= 1'b0;
		end
	end

	// activity and standby; idle time draws no switching, so power tracks rate
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			CONVERTING <= 1'b0;
			POWER_DOWN <= 1'b1;
		end else if (state_reg == ST_ACQ && start_rise) begin
			CONVERTING <= 1'b1;
			POWER_DOWN <= 1'b0;
		end else if (state_reg == ST_DONE) begin
			CONVERTING <= 1'b0;
			POWER_DOWN <= 1'b1;
		end
	end

	// an edge seen while converting is dropped, but reported for diagnosis
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			START_IGNORED <= 1'b0;
		end else begin
			START_IGNORED <= start_rise & (state_reg != ST_ACQ);
		end
	end

	// one sample costs 2 switch steps, RES_BITS*BIT_CYCLES trials and 2 end
	// steps; at 1 cycle per bit that is 20 clocks, and the ACQ clock that takes
	// the edge makes 21, one more than the sample period at the highest rate, so
	// an edge arriving 20 clocks after the last one lands in DONE and is dropped

endmodule // scs_sequencer

// ### verilog/scs_map.vh
`ifndef SCS_MAP_VH
`define SCS_MAP_VH

// resolution of the converter
`define SCS_RES_BITS        16
// system clock rate in hertz
`define SCS_CLK_HZ          20000000
// highest back-to-back conversion rate in samples per second
`define SCS_MAX_RATE_SPS    1000000
// clocks available per sample at the highest rate (rounded down)
`define SCS_SAMPLE_CYCLES   (`SCS_CLK_HZ / `SCS_MAX_RATE_SPS)
// clocks spent on each bit decision
`define SCS_BIT_CYCLES      1

// straight binary reference codes
`define SCS_CODE_ZERO       16'h0000
`define SCS_CODE_MID        16'h8000
`define SCS_CODE_FULL       16'hffff

// state codes, one-hot
`define SCS_ST_W            5
`define SCS_ST_ACQ          5'h01
`define SCS_ST_OPEN         5'h02
`define SCS_ST_DISC         5'h04
`define SCS_ST_CONV         5'h08
`define SCS_ST_DONE         5'h10

`endif

// ### verilog/scs_sar_core.v
`timescale 1ns/1ps
`include "scs_map.vh"

module scs_sar_core #(
	parameter N = `SCS_RES_BITS
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire         start,
	input  wire         step,
	input  wire         decision,
	output reg  [N-1:0] code_reg,
	output reg          done_reg
);

	reg  [N-1:0] ptr_reg;
	wire [N-1:0] code_next;
	wire [N-1:0] ptr_next;
	wire [N-1:0] ptr_shift;

	assign ptr_shift = {1'b0, ptr_reg[N-1:1]};

	// per-bit update: keep or drop the bit on trial, raise the next one
	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_bit
			if (i == N - 1) begin : g_msb
				assign code_next[i] = start ? 1'b1 :
					(step && ptr_reg[i]) ? decision : code_reg[i];
			end else begin : g_low
				assign code_next[i] = start ? 1'b0 :
					(step && ptr_reg[i]) ? decision :
					(step && ptr_reg[i+1]) ? 1'b1 : code_reg[i];
			end
		end
	endgenerate

	// pointer walks from the most significant bit down
	assign ptr_next = start ? {1'b1, {(N-1){1'b0}}} :
		step ? ptr_shift : ptr_reg;

	// done pulses with the edge that resolves the last bit
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			code_reg <= {N{1'b0}};
			ptr_reg  <= {N{1'b0}};
			done_reg <= 1'b0;
		end else begin
			code_reg <= code_next;
			ptr_reg  <= ptr_next;
			done_reg <= step & ptr_reg[0] & ~start;
		end
	end

endmodule // scs_sar_core

// ### tb/scs_analog_model.sv
`timescale 1ns/1ps

// comparator seen by the trial array; the held input is a steady code
module scs_analog_model (
	input  wire [15:0] dac_code,
	input  wire [15:0] level,
	output wire        decision
);
	// keep the trial bit while the input reaches it; no settling delay modelled
	assign decision = (level >= dac_code);
endmodule // scs_analog_model

// ### tb/scs_seq_sva.sv
`timescale 1ns/1ps

// timing of one conversion as seen at the sequencer pins
module scs_seq_sva #(
	parameter RES_BITS = 16
) (
	input wire                SYS_CLK,
	input wire                RST_N,
	input wire                OVER_RANGE,
	input wire                UNDER_RANGE,
	input wire                POSITIVE_ARRAY_SHORT_SWITCH,
	input wire                NEGATIVE_ARRAY_SHORT_SWITCH,
	input wire                ARRAY_TO_INPUT,
	input wire                ARRAY_TO_GROUND,
	input wire [RES_BITS-1:0] DAC_CODE,
	input wire [RES_BITS-1:0] RESULT,
	input wire                RESULT_VALID,
	input wire                BUSY_INDICATOR,
	input wire                CONVERTING,
	input wire                POWER_DOWN
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	// shorts open first, arrays move to ground one cycle later
	sequence s_open;
		!POSITIVE_ARRAY_SHORT_SWITCH && !NEGATIVE_ARRAY_SHORT_SWITCH && ARRAY_TO_INPUT;
	endsequence
	sequence s_ground;
		!ARRAY_TO_INPUT && ARRAY_TO_GROUND;
	endsequence
	property p_switch_order;
		$rose(CONVERTING) |-> s_open ##1 s_ground;
	endproperty
	a_switch_order: assert property (p_switch_order) else $error("switch order wrong");

	property p_msb_first;
		$rose(CONVERTING) |-> ##2 DAC_CODE == 16'h8000;
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("first trial not msb");

	property p_conv_len;
		$rose(CONVERTING) |-> ##19 RESULT_VALID;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

	property p_no_abort;
		CONVERTING && !RESULT_VALID |=> CONVERTING;
	endproperty
	a_no_abort: assert property (p_no_abort) else $error("conversion stopped early");

	// after the result the block is back in acquisition and idle
	property p_back_acq;
		RESULT_VALID |=> !RESULT_VALID && POWER_DOWN && !CONVERTING
			&& POSITIVE_ARRAY_SHORT_SWITCH && ARRAY_TO_INPUT;
	endproperty
	a_back_acq: assert property (p_back_acq) else $error("no return to idle");

	property p_hold;
		!RESULT_VALID |-> $stable(RESULT);
	endproperty
	a_hold: assert property (p_hold) else $error("result changed without valid");

	property p_busy_clr;
		$rose(CONVERTING) |-> !BUSY_INDICATOR;
	endproperty
	a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared");

	// range flags pass two sync flops, so look back past them
	property p_over;
		RESULT_VALID && $past(OVER_RANGE, 2) && $past(OVER_RANGE, 3) |-> RESULT == 16'hffff;
	endproperty
	a_over: assert property (p_over) else $error("overrange not clamped");

	property p_under;
		RESULT_VALID && !$past(OVER_RANGE, 2) && !$past(OVER_RANGE, 3)
			&& $past(UNDER_RANGE, 2) && $past(UNDER_RANGE, 3) |-> RESULT == 16'h0000;
	endproperty
	a_under: assert property (p_under) else $error("underrange not clamped");
endmodule // scs_seq_sva

bind scs_sequencer scs_seq_sva #(.RES_BITS(RES_BITS)) i_scs_seq_sva (.SYS_CLK, .RST_N,
	.OVER_RANGE, .UNDER_RANGE, .POSITIVE_ARRAY_SHORT_SWITCH, .NEGATIVE_ARRAY_SHORT_SWITCH,
	.ARRAY_TO_INPUT, .ARRAY_TO_GROUND, .DAC_CODE, .RESULT, .RESULT_VALID, .BUSY_INDICATOR,
	.CONVERTING, .POWER_DOWN);

// ### tb/sar_conversion_sequencer_tb.sv
`timescale 1ns/1ps

module sar_conversion_sequencer_tb;
	reg            sys_clk = 1'b0;
	reg            rst_n = 1'b0;
	reg            start = 1'b0;
	reg            serial_in_mode_select = 1'b0;
	reg            over = 1'b0;
	reg            under = 1'b0;
	reg     [15:0] level = 16'h0000;
	reg     [15:0] code;
	reg            bsy;
	reg            csm;
	reg            ign_seen;
	wire           cs_md;
	wire           ign;
	wire           decision;
	wire    [15:0] dac_code;
	wire    [15:0] result;
	wire           valid;
	wire           busy;
	wire           running;
	wire           pd;
	integer        fails = 0;
	integer        checked = 0;
	integer        cycles = 0;

	always #25 sys_clk = ~sys_clk;

	scs_sequencer i_scs_sequencer (.SYS_CLK(sys_clk), .RST_N(rst_n),
		.CONVERSION_START_INPUT(start), .SERIAL_IN_MODE_SELECT(serial_in_mode_select), .COMP_DECISION(decision),
		.OVER_RANGE(over), .UNDER_RANGE(under), .POSITIVE_ARRAY_SHORT_SWITCH(),
		.NEGATIVE_ARRAY_SHORT_SWITCH(), .ARRAY_TO_INPUT(), .ARRAY_TO_GROUND(),
		.DAC_CODE(dac_code), .RESULT(result), .RESULT_VALID(valid), .BUSY_INDICATOR(busy),
		.CONVERTING(running), .POWER_DOWN(pd), .CS_MODE(cs_md), .START_IGNORED(ign));
	scs_analog_model i_scs_analog_model (.dac_code(dac_code), .level(level), .decision(decision));

	task complete_run;
		begin
			if (fails == 0 && checked > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask

	task chk16(input [15:0] got, input [15:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("ERROR %0t code %h expected %h", $time, got, exp);
			end
		end
	endtask

	task chk1(input got, input exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("ERROR %0t flag %b expected %b", $time, got, exp);
			end
		end
	endtask

	// one conversion; early drops start mid-run and adds an edge that must be ignored
	task convert(input [15:0] v, input ov, input un, input md, input early);
		integer n;
		begin
			@(posedge sys_clk);
			level <= v;
			over <= ov;
			under <= un;
			serial_in_mode_select <= md;
			start <= 1'b1;
			ign_seen = 1'b0;
			n = 0;
			while (running !== 1'b1 && n < 10) begin
				@(posedge sys_clk);
				#1;
				n = n + 1;
			end
			if (early) begin
				@(posedge sys_clk);
				start <= 1'b0;
				repeat (3) @(posedge sys_clk);
				start <= 1'b1;
				repeat (3) @(posedge sys_clk);
				start <= 1'b0;
				// the late edge is registered as ignored at this edge
				#1;
				ign_seen = ign;
			end
			n = 0;
			while (valid !== 1'b1 && n < 30) begin
				@(posedge sys_clk);
				#1;
				n = n + 1;
			end
			chk1(valid, 1'b1);
			code = result;
			bsy = busy;
			csm = cs_md;
			@(posedge sys_clk);
			start <= 1'b0;
			#1;
			chk1(pd, 1'b1);
			repeat (4) @(posedge sys_clk);
		end
	endtask

	// boundary codes of the straight binary scale
	task t_codes;
		reg [95:0] tbl;
		integer i;
		begin
			tbl = {16'h0000, 16'h0001, 16'h7fff, 16'h8000, 16'h8001, 16'hffff};
			for (i = 0; i < 6; i = i + 1) begin
				convert(tbl[i*16 +: 16], 1'b0, 1'b0, 1'b1, 1'b0);
				chk16(code, tbl[i*16 +: 16]);
			end
		end
	endtask

	task t_clamp;
		begin
			convert(16'h1234, 1'b1, 1'b0, 1'b1, 1'b0);
			chk16(code, 16'hffff);
			convert(16'h4321, 1'b0, 1'b1, 1'b1, 1'b0);
			chk16(code, 16'h0000);
		end
	endtask

	// each result must belong to its own start edge
	task t_back2back;
		begin
			convert(16'h5a5a, 1'b0, 1'b0, 1'b1, 1'b0);
			chk16(code, 16'h5a5a);
			convert(16'ha5a5, 1'b0, 1'b0, 1'b1, 1'b0);
			chk16(code, 16'ha5a5);
		end
	endtask

	// chain mode with start toggled mid-conversion
	task t_abort;
		begin
			convert(16'h3c3c, 1'b0, 1'b0, 1'b0, 1'b1);
			chk16(code, 16'h3c3c);
			chk1(bsy, 1'b0);
			chk1(csm, 1'b0);
			chk1(ign_seen, 1'b1);
		end
	endtask

	// select mode: busy only when start or serial is low at the end
	task t_busy;
		begin
			convert(16'h0f0f, 1'b0, 1'b0, 1'b1, 1'b1);
			chk1(bsy, 1'b1);
			chk1(csm, 1'b1);
			chk1(ign_seen, 1'b1);
			convert(16'hf0f0, 1'b0, 1'b0, 1'b1, 1'b0);
			chk1(bsy, 1'b0);
		end
	endtask

	// hang guard, well above the few hundred cycles needed
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fails = fails + 1;
			complete_run;
		end
	end

	// reset, then the scenarios in turn
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_codes;
		t_clamp;
		t_back2back;
		t_abort;
		t_busy;
		complete_run;
	end
endmodule // sar_conversion_sequencer_tb
